// [logic/from_pkg.sv]
// Package for the fault record and fault output map block: offsets, codes, field layout, resets and carriers.
package from_pkg;
	// Register byte offsets on the APB slave.
	localparam logic [7:0] OFS_OH_LEVEL = 8'h00;
	localparam logic [7:0] OFS_STALL_LIMIT = 8'h04;
	localparam logic [7:0] OFS_RECORD = 8'h08;
	localparam logic [7:0] OFS_OPTION_1 = 8'h0C;
	localparam logic [7:0] OFS_OPTION_2 = 8'h10;
	localparam logic [7:0] OFS_OPTION_3 = 8'h14;
	localparam logic [7:0] OFS_OPTION_4 = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;
	localparam logic [7:0] OFS_CLEAR = 8'h20;
	// Reset values, ranges and trip levels; temperatures in 0.1 degC units, limit in percent.
	localparam logic [15:0] RST_OH_LEVEL = 16'h041A;
	localparam logic [15:0] RST_STALL_LIMIT = 16'h0064;
	localparam logic [15:0] RST_OPTION = 16'h0000;
	localparam logic [7:0] RST_RECORD = 8'h00;
	localparam logic [15:0] MAX_OH_LEVEL = 16'h044C;
	localparam logic [15:0] MAX_STALL_LIMIT = 16'h0064;
	localparam logic [15:0] OH_TRIP_HEAVY = 16'h03E8;
	localparam logic [15:0] OH_TRIP_NORMAL = 16'h044C;
	localparam logic [15:0] PCT_FULL = 16'h0064;
	// Category bit positions inside each option value.
	localparam int CAT_CURRENT = 0;
	localparam int CAT_VOLTAGE = 1;
	localparam int CAT_OVERLOAD = 2;
	localparam int CAT_SYSTEM = 3;
	localparam int CAT_FEEDBACK = 4;
	localparam int CAT_EXTERNAL = 5;
	localparam int CAT_COMM = 6;
	localparam int CAT_W = 7;
	// Multi-function output terminal function codes for the four options.
	localparam logic [7:0] MFO_OPTION_BASE = 8'h23;
	localparam int MFO_COUNT = 4;
	// Fault codes.
	localparam logic [7:0] FC_NONE = 8'h00;
	localparam logic [7:0] FC_OC_ACC = 8'h01;
	localparam logic [7:0] FC_OC_DEC = 8'h02;
	localparam logic [7:0] FC_OC_RUN = 8'h03;
	localparam logic [7:0] FC_GROUND = 8'h04;
	localparam logic [7:0] FC_OC_STOP = 8'h06;
	localparam logic [7:0] FC_OV_ACC = 8'h07;
	localparam logic [7:0] FC_OV_STOP = 8'h0A;
	localparam logic [7:0] FC_UV_ACC = 8'h0B;
	localparam logic [7:0] FC_UV_STOP = 8'h0E;
	localparam logic [7:0] FC_PHASE_LOSS = 8'h0F;
	localparam logic [7:0] FC_STAGE_HOT = 8'h10;
	localparam logic [7:0] FC_SENSOR_OPEN = 8'h12;
	localparam logic [7:0] FC_OVERLOAD = 8'h15;
	localparam logic [7:0] FC_THERMAL_2 = 8'h17;
	localparam logic [7:0] FC_THERMISTOR = 8'h18;
	localparam logic [7:0] FC_TORQUE_1 = 8'h1A;
	localparam logic [7:0] FC_TORQUE_2 = 8'h1B;
	localparam logic [7:0] FC_LOW_CURRENT = 8'h1C;
	localparam logic [7:0] FC_MEM_ERR = 8'h1F;
	localparam logic [7:0] FC_SENSE_U = 8'h21;
	localparam logic [7:0] FC_AUTOTUNE = 8'h28;
	localparam logic [7:0] FC_CTRL_FB = 8'h29;
	localparam logic [7:0] FC_ENC_ERR = 8'h2A;
	localparam logic [7:0] FC_ENC_SLIP = 8'h2D;
	localparam logic [7:0] FC_AIN_LOSS = 8'h30;
	localparam logic [7:0] FC_EXT_FAULT = 8'h31;
	localparam logic [7:0] FC_EXT_BLOCK = 8'h33;
	localparam logic [7:0] FC_PASSWORD = 8'h34;
	localparam logic [7:0] FC_SERIAL_1 = 8'h36;
	localparam logic [7:0] FC_SERIAL_4 = 8'h39;
	localparam logic [7:0] FC_TIMEOUT = 8'h3A;
	localparam logic [7:0] FC_STAR_SWITCH = 8'h3D;
	localparam logic [7:0] FC_BACKUP = 8'h3E;
	localparam logic [7:0] FC_SLIP = 8'h3F;
	localparam logic [7:0] FC_SAFE_1 = 8'h48;
	localparam logic [7:0] FC_SAFE_TORQUE = 8'h4C;
	localparam logic [7:0] FC_SAFE_3 = 8'h4E;
	localparam logic [7:0] FC_OC_PRE_U = 8'h4F;
	localparam logic [7:0] FC_OC_PRE_V = 8'h50;
	localparam logic [7:0] FC_OPL_U = 8'h52;
	localparam logic [7:0] FC_OPL_W = 8'h54;
	localparam logic [7:0] FC_LOWF_OVERLOAD = 8'h57;
	localparam logic [7:0] FC_ROTOR_POS = 8'h59;
	localparam logic [7:0] FC_CAN_SW_1 = 8'h65;
	localparam logic [7:0] FC_CAN_SW_2 = 8'h66;
	localparam logic [7:0] FC_CAN_HW = 8'h68;
	localparam logic [7:0] FC_CAN_MEM = 8'h6B;
	localparam logic [7:0] FC_INT_COMM_0 = 8'h79;
	localparam logic [7:0] FC_INT_COMM_1 = 8'h7B;
	localparam logic [7:0] FC_INT_COMM_2 = 8'h7C;
	localparam logic [7:0] FC_INT_COMM_3 = 8'h7E;
	localparam logic [7:0] FC_SW_VERSION = 8'h7F;
	localparam logic [7:0] FC_TORQUE_3 = 8'h80;
	localparam logic [7:0] FC_TORQUE_4 = 8'h81;
	localparam logic [7:0] FC_THERMAL_3 = 8'h86;
	localparam logic [7:0] FC_THERMAL_4 = 8'h87;
	localparam logic [7:0] FC_GF_POWERON = 8'h8C;
	localparam logic [7:0] FC_GF_PRERUN = 8'h8D;
	localparam logic [7:0] FC_TUNE_STAGE_1 = 8'h8E;
	localparam logic [7:0] FC_TUNE_STAGE_3 = 8'h90;
	// Motion phase of the drive when a fault is raised.
	typedef enum logic [1:0] {
		FROM_PH_ACC = 2'h0,
		FROM_PH_DEC = 2'h1,
		FROM_PH_RUN = 2'h2,
		FROM_PH_STOP = 2'h3
	} from_phase_t;
	// A fault report from the protection detectors.
	typedef struct packed {
		logic valid;
		logic [7:0] code;
	} from_fault_t;
	// Scaled stall levels handed to the stall prevention logic.
	typedef struct packed {
		logic [15:0] accel;
		logic [15:0] run;
	} from_stall_t;
endpackage : from_pkg

// [logic/from_fault_map.sv]
// Fault record, fault-to-terminal mapping, over-heat warning and stall limit scaling.
// Operation
// (RULE1) Stopping fault code stored; zero means none.
// (RULE2) Undervoltage at stop warns only, no record.
// (RULE3) Energy backup execution records code 62.
// (RULE4) Over-current codes 1-3, ground 4, stop 6.
// (RULE5) Over-voltage 7-10, undervoltage 11-14, phase loss 15.
// (RULE6) Thermal and load fault codes 16 to 28.
// (RULE7) Internal detection fault codes 31 to 40.
// (RULE8) Feedback fault codes 41 to 48.
// (RULE9) External fault codes 49-51, password 52.
// (RULE10) Serial errors 54-57, time-out 58.
// (RULE11) Codes 61-63, safety 72/76-78.
// (RULE12) Pre-run over-current, phase loss, 87, 89.
// (RULE13) CANopen and internal communication codes 101-127.
// (RULE14) Extended fault codes 128 to 144.
// (RULE15) Four 16-bit option values, default zero.
// (RULE16) Terminal functions 35-38 follow matching categories.
// (RULE17) Category bits zero to six as listed.
// (RULE18) Stop over-current current; over-voltage voltage category.
// (RULE19) Warning threshold 0.0-110.0 degC, default 105.0.
// (RULE20) Heavy or sensorless mode trips at 100 degC.
// (RULE21) Other modes trip at 110 degC.
// (RULE22) Above base frequency stall levels scaled by percent.
// (RULE23) Over-torque overload; feedback loss and slip feedback.
// (RULE24) Terminal idle while no matching active fault.
`timescale 1ns/100ps
module from_fault_map (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst_n,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Protection detectors.
	input wire from_pkg::from_fault_t fault_in,
	input wire from_pkg::from_phase_t drive_phase,
	input wire logic decel_energy_backup,
	input wire logic heavy_or_sensorless,
	input wire logic [15:0] heatsink_temp,
	input wire logic above_base_freq,
	input wire from_pkg::from_stall_t stall_base,
	// Terminal configuration and outputs.
	input wire logic [7:0] terminal_func [from_pkg::MFO_COUNT],
	output logic [from_pkg::MFO_COUNT-1:0] terminal_out,
	output logic overheat_warning,
	output logic undervoltage_at_stop,
	output logic overheat_trip,
	output from_pkg::from_stall_t stall_level
);
	logic [15:0] oh_level_ff, nxt_oh_level;
	logic [15:0] stall_limit_ff, nxt_stall_limit;
	logic [15:0] option_ff [from_pkg::MFO_COUNT];
	logic [15:0] nxt_option [from_pkg::MFO_COUNT];
	logic [7:0] record_ff, nxt_record;
	logic [7:0] active_ff, nxt_active;
	logic [31:0] nxt_prdata;
	logic [from_pkg::MFO_COUNT-1:0] nxt_terminal;
	logic nxt_warn, nxt_uvs, nxt_trip;
	from_pkg::from_stall_t nxt_stall;
	logic [from_pkg::CAT_W-1:0] cat;
	logic wr_en, rd_en, clear_req, record_ev;
	logic [7:0] ev_code;
	logic [31:0] acc_prod, run_prod;

	// Category of a fault code; codes the map leaves blank fall into no category.
	function automatic logic [from_pkg::CAT_W-1:0] category(input logic [7:0] c);
		logic [from_pkg::CAT_W-1:0] r;
		r = '0;
		if (c == from_pkg::FC_OC_ACC || c == from_pkg::FC_OC_STOP || c == from_pkg::FC_LOW_CURRENT ||
			c == from_pkg::FC_OC_PRE_U || c == from_pkg::FC_OC_PRE_V || c == from_pkg::FC_OPL_U) begin
			r[from_pkg::CAT_CURRENT] = 1'b1; // see (RULE18)
		end
		if ((c >= from_pkg::FC_OV_ACC && c <= from_pkg::FC_PHASE_LOSS) || c == from_pkg::FC_BACKUP) begin
			r[from_pkg::CAT_VOLTAGE] = 1'b1; // see (RULE18)
		end
		if (c == from_pkg::FC_OVERLOAD || c == from_pkg::FC_TORQUE_1 || c == from_pkg::FC_TORQUE_2 ||
			c == from_pkg::FC_LOWF_OVERLOAD) begin
			r[from_pkg::CAT_OVERLOAD] = 1'b1; // see (RULE23)
		end
		if ((c >= from_pkg::FC_MEM_ERR && c <= from_pkg::FC_AUTOTUNE && c != 8'h20) ||
			c == from_pkg::FC_PASSWORD || c == from_pkg::FC_SAFE_1 ||
			(c >= from_pkg::FC_SAFE_TORQUE && c <= from_pkg::FC_SAFE_3)) begin
			r[from_pkg::CAT_SYSTEM] = 1'b1; // see (RULE17)
		end
		if ((c >= from_pkg::FC_CTRL_FB && c <= from_pkg::FC_ENC_SLIP) || c == from_pkg::FC_AIN_LOSS ||
			c == from_pkg::FC_ROTOR_POS) begin
			r[from_pkg::CAT_FEEDBACK] = 1'b1; // see (RULE23)
		end
		if ((c >= from_pkg::FC_EXT_FAULT && c <= from_pkg::FC_EXT_BLOCK) ||
			c == from_pkg::FC_STAR_SWITCH || c == from_pkg::FC_SLIP) begin
			r[from_pkg::CAT_EXTERNAL] = 1'b1; // see (RULE17)
		end
		if ((c >= from_pkg::FC_SERIAL_1 && c <= from_pkg::FC_TIMEOUT) ||
			(c >= from_pkg::FC_CAN_SW_1 && c <= from_pkg::FC_CAN_MEM && c != 8'h67) ||
			c == from_pkg::FC_INT_COMM_0 || c == from_pkg::FC_INT_COMM_1 ||
			c == from_pkg::FC_INT_COMM_2 || c == from_pkg::FC_INT_COMM_3) begin
			r[from_pkg::CAT_COMM] = 1'b1; // see (RULE17)
		end
		return r;
	endfunction : category

	// The detectors only ever raise documented codes; the record stores them as given.
	// see (RULE4) (RULE5) (RULE6) (RULE7) (RULE8) (RULE9) (RULE10) (RULE11) (RULE12) (RULE13) (RULE14)
	always_comb begin
		ev_code = fault_in.code;
		record_ev = 1'b0;
		nxt_uvs = 1'b0;
		if (decel_energy_backup) begin
			ev_code = from_pkg::FC_BACKUP; // see (RULE3)
			record_ev = 1'b1;
		end else if (fault_in.valid && fault_in.code != from_pkg::FC_NONE) begin
			if (fault_in.code == from_pkg::FC_UV_STOP ||
				(fault_in.code >= from_pkg::FC_UV_ACC && fault_in.code < from_pkg::FC_UV_STOP &&
				drive_phase == from_pkg::FROM_PH_STOP)) begin
				nxt_uvs = 1'b1; // see (RULE2)
			end else begin
				record_ev = 1'b1; // see (RULE1)
			end
		end
	end

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	assign clear_req = wr_en && paddr == from_pkg::OFS_CLEAR && pwdata[0];
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	always_comb begin
		nxt_oh_level = oh_level_ff;
		nxt_stall_limit = stall_limit_ff;
		nxt_option = option_ff;
		nxt_record = record_ev ? ev_code : record_ff; // see (RULE1)
		nxt_active = record_ev ? ev_code : active_ff;
		if (clear_req && !record_ev) begin
			nxt_active = from_pkg::FC_NONE;
		end
		if (wr_en) begin
			unique case (paddr)
				from_pkg::OFS_OH_LEVEL: if (pwdata[15:0] <= from_pkg::MAX_OH_LEVEL) begin
					nxt_oh_level = pwdata[15:0]; // see (RULE19)
				end
				from_pkg::OFS_STALL_LIMIT: if (pwdata[15:0] <= from_pkg::MAX_STALL_LIMIT) begin
					nxt_stall_limit = pwdata[15:0]; // see (RULE22)
				end
				from_pkg::OFS_OPTION_1: nxt_option[0] = pwdata[15:0]; // see (RULE15)
				from_pkg::OFS_OPTION_2: nxt_option[1] = pwdata[15:0];
				from_pkg::OFS_OPTION_3: nxt_option[2] = pwdata[15:0];
				from_pkg::OFS_OPTION_4: nxt_option[3] = pwdata[15:0];
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		nxt_prdata = prdata;
		if (rd_en) begin
			unique case (paddr)
				from_pkg::OFS_OH_LEVEL: nxt_prdata = {16'h0000, oh_level_ff};
				from_pkg::OFS_STALL_LIMIT: nxt_prdata = {16'h0000, stall_limit_ff};
				from_pkg::OFS_RECORD: nxt_prdata = {24'h00_0000, record_ff};
				from_pkg::OFS_OPTION_1: nxt_prdata = {16'h0000, option_ff[0]};
				from_pkg::OFS_OPTION_2: nxt_prdata = {16'h0000, option_ff[1]};
				from_pkg::OFS_OPTION_3: nxt_prdata = {16'h0000, option_ff[2]};
				from_pkg::OFS_OPTION_4: nxt_prdata = {16'h0000, option_ff[3]};
				from_pkg::OFS_STATUS: nxt_prdata = {16'h0000, 5'h00, overheat_trip, overheat_warning,
					undervoltage_at_stop, active_ff};
				default: nxt_prdata = 32'h0000_0000;
			endcase
		end
	end

	// Terminals, heat supervision and stall scaling.
	assign cat = category(active_ff);
	assign acc_prod = 32'(stall_base.accel) * 32'(stall_limit_ff);
	assign run_prod = 32'(stall_base.run) * 32'(stall_limit_ff);
	always_comb begin
		for (int i = 0; i < from_pkg::MFO_COUNT; i++) begin
			nxt_terminal[i] = terminal_func[i] == from_pkg::MFO_OPTION_BASE + 8'(i) &&
				|(cat & option_ff[i][from_pkg::CAT_W-1:0]); // see (RULE16) (RULE24)
		end
		// The fixed trip applies whatever the warning threshold; in heavy mode a threshold at or above it masks the warning.
		nxt_trip = heavy_or_sensorless ? heatsink_temp >= from_pkg::OH_TRIP_HEAVY // see (RULE20)
			: heatsink_temp >= from_pkg::OH_TRIP_NORMAL; // see (RULE21)
		nxt_warn = heatsink_temp >= oh_level_ff && !(heavy_or_sensorless && oh_level_ff >= from_pkg::OH_TRIP_HEAVY);
		nxt_stall = stall_base;
		if (above_base_freq) begin
			nxt_stall.accel = 16'(acc_prod / 32'(from_pkg::PCT_FULL)); // see (RULE22)
			nxt_stall.run = 16'(run_prod / 32'(from_pkg::PCT_FULL));
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			oh_level_ff <= from_pkg::RST_OH_LEVEL;
			stall_limit_ff <= from_pkg::RST_STALL_LIMIT;
			for (int i = 0; i < from_pkg::MFO_COUNT; i++) begin
				option_ff[i] <= from_pkg::RST_OPTION;
			end
			record_ff <= from_pkg::RST_RECORD;
			active_ff <= from_pkg::RST_RECORD;
			prdata <= 32'h0000_0000;
			terminal_out <= '0;
			overheat_warning <= 1'b0;
			undervoltage_at_stop <= 1'b0;
			overheat_trip <= 1'b0;
			stall_level <= '0;
		end else begin
			oh_level_ff <= nxt_oh_level;
			stall_limit_ff <= nxt_stall_limit;
			option_ff <= nxt_option;
			record_ff <= nxt_record;
			active_ff <= nxt_active;
			prdata <= nxt_prdata;
			terminal_out <= nxt_terminal;
			overheat_warning <= nxt_warn;
			undervoltage_at_stop <= nxt_uvs;
			overheat_trip <= nxt_trip;
			stall_level <= nxt_stall;
		end
	end

	sequence backup_seen_s;
		decel_energy_backup;
	endsequence
	sequence backup_logged_s;
		##1 record_ff == from_pkg::FC_BACKUP;
	endsequence

	record_on_fault_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE1)
		fault_in.valid && fault_in.code != from_pkg::FC_NONE && !decel_energy_backup &&
		(fault_in.code < from_pkg::FC_UV_ACC || fault_in.code > from_pkg::FC_UV_STOP)
		|=> record_ff == $past(fault_in.code)) else $error("fault code not recorded");
	uv_stop_norec_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE2)
		fault_in.valid && fault_in.code == from_pkg::FC_UV_STOP && !decel_energy_backup
		|=> record_ff == $past(record_ff) && undervoltage_at_stop) else $error("stop undervoltage recorded");
	backup_record_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE3)
		backup_seen_s |-> backup_logged_s) else $error("backup code missing");
	option_reset_a: assert property (@(posedge sys_clk) $rose(rst_n) |-> option_ff[0] == 16'h0000 // see (RULE15)
		&& oh_level_ff == from_pkg::RST_OH_LEVEL) else $error("reset defaults wrong");
	terminal_match_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE16)
		terminal_out[0] |-> $past(terminal_func[0]) == from_pkg::MFO_OPTION_BASE
		&& |($past(cat) & $past(option_ff[0][from_pkg::CAT_W-1:0]))) else $error("terminal without match");
	terminal_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE24)
		active_ff == from_pkg::FC_NONE [*2] |-> terminal_out == '0) else $error("terminal active with no fault");
	heavy_trip_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE20)
		heavy_or_sensorless && heatsink_temp >= from_pkg::OH_TRIP_HEAVY |=> overheat_trip) else $error("no heavy trip");
	normal_trip_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE21)
		!heavy_or_sensorless && heatsink_temp < from_pkg::OH_TRIP_NORMAL |=> !overheat_trip) else $error("early trip");
	warn_level_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE19)
		!heavy_or_sensorless && heatsink_temp < oh_level_ff |=> !overheat_warning) else $error("early warning");
	stall_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE22)
		!above_base_freq |=> stall_level == $past(stall_base)) else $error("stall scaled below base");
	limit_range_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE22)
		stall_limit_ff <= from_pkg::MAX_STALL_LIMIT) else $error("limit out of range");

	// A clear that meets a new fault in the same cycle loses, so a fault is never dropped.
	active_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE1)
		record_ev
		|=> active_ff == $past(ev_code)) else $error("active fault not taken");
	clear_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE24)
		clear_req && !record_ev
		|=> active_ff == from_pkg::FC_NONE) else $error("active fault not cleared");
	record_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE1)
		!record_ev
		|=> $stable(record_ff)) else $error("record changed without fault");
	uv_run_record_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE2)
		fault_in.valid && fault_in.code >= from_pkg::FC_UV_ACC && fault_in.code < from_pkg::FC_UV_STOP &&
		drive_phase != from_pkg::FROM_PH_STOP && !decel_energy_backup
		|=> record_ff == $past(fault_in.code)) else $error("running undervoltage not recorded");
	status_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE1)
		rd_en && paddr == from_pkg::OFS_STATUS
		|=> prdata[7:0] == $past(active_ff)) else $error("status code wrong");

	// In-range writes land; out-of-range ones keep the old setting rather than clipping it.
	level_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE19)
		wr_en && paddr == from_pkg::OFS_OH_LEVEL && pwdata[15:0] <= from_pkg::MAX_OH_LEVEL
		|=> oh_level_ff == $past(pwdata[15:0])) else $error("level write lost");
	level_refuse_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE19)
		wr_en && paddr == from_pkg::OFS_OH_LEVEL && pwdata[15:0] > from_pkg::MAX_OH_LEVEL
		|=> $stable(oh_level_ff)) else $error("level out of range taken");
	option_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE15)
		wr_en && paddr == from_pkg::OFS_OPTION_4
		|=> option_ff[3] == $past(pwdata[15:0])) else $error("option write lost");
	terminal_func_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE16)
		terminal_out[3]
		|-> $past(terminal_func[3]) == from_pkg::MFO_OPTION_BASE + 8'h03) else $error("terminal function ignored");

	// Heat supervision.
	warn_reach_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE19)
		!heavy_or_sensorless && heatsink_temp >= oh_level_ff
		|=> overheat_warning) else $error("warning missing");
	heavy_warn_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE20)
		heavy_or_sensorless && oh_level_ff >= from_pkg::OH_TRIP_HEAVY
		|=> !overheat_warning) else $error("heavy warning not masked");
	heavy_warn_on_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE20)
		heavy_or_sensorless && oh_level_ff < from_pkg::OH_TRIP_HEAVY && heatsink_temp >= oh_level_ff
		|=> overheat_warning) else $error("lowered heavy warning missing");
	normal_reach_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE21)
		!heavy_or_sensorless && heatsink_temp >= from_pkg::OH_TRIP_NORMAL
		|=> overheat_trip) else $error("no normal trip");

	// The limit never exceeds full scale, so scaling can only lower the levels.
	stall_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see (RULE22)
		above_base_freq
		|=> stall_level.accel <= $past(stall_base.accel) && stall_level.run <= $past(stall_base.run))
		else $error("stall level raised");
endmodule : from_fault_map

// [test/from_detector_model.sv]
// Behavioural model of the protection detectors that report faults and energy backup events.
`timescale 1ns/100ps
module from_detector_model (
	// Clock.
	input wire logic sys_clk,
	// Detector reports.
	output from_pkg::from_fault_t fault_in,
	output from_pkg::from_phase_t drive_phase,
	output logic decel_energy_backup
);
	initial begin
		fault_in = '0;
		drive_phase = from_pkg::FROM_PH_STOP;
		decel_energy_backup = 1'b0;
	end
	// Each report lasts one cycle, since a held valid would be taken as a second event.
	task automatic raise_fault(input logic [7:0] c, input from_pkg::from_phase_t ph);
		@(posedge sys_clk);
		drive_phase <= ph;
		fault_in <= {1'b1, c};
		@(posedge sys_clk);
		fault_in <= {1'b0, c};
	endtask : raise_fault
	task automatic fire_backup();
		@(posedge sys_clk);
		decel_energy_backup <= 1'b1;
		@(posedge sys_clk);
		decel_energy_backup <= 1'b0;
	endtask : fire_backup
endmodule : from_detector_model

// [test/fault_record_output_map_tb.sv]
// Self-checking testbench for the fault record and fault output map block.
`timescale 1ns/100ps
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
	$display("unexpected %s: expected %h, seen %h", what, exp, got); end end
module fault_record_output_map_tb;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	from_pkg::from_fault_t fault_in;
	from_pkg::from_phase_t drive_phase;
	logic decel_energy_backup;
	logic heavy_or_sensorless = 1'b0;
	logic [15:0] heatsink_temp = 16'h0000;
	logic above_base_freq = 1'b0;
	from_pkg::from_stall_t stall_base = '0;
	logic [7:0] terminal_func [from_pkg::MFO_COUNT] = '{8'h23, 8'h24, 8'h25, 8'h26};
	logic [from_pkg::MFO_COUNT-1:0] terminal_out;
	logic overheat_warning;
	logic undervoltage_at_stop;
	logic overheat_trip;
	from_pkg::from_stall_t stall_level;
	int err_count = 0;
	int tests_run = 0;
	logic [7:0] cat_code [7] = '{from_pkg::FC_OC_STOP, from_pkg::FC_OV_ACC, from_pkg::FC_TORQUE_2,
		from_pkg::FC_MEM_ERR, from_pkg::FC_ENC_SLIP, from_pkg::FC_EXT_FAULT, from_pkg::FC_TIMEOUT};
	always #4 sys_clk = ~sys_clk;
	from_detector_model i_det (.sys_clk(sys_clk), .fault_in(fault_in), .drive_phase(drive_phase),
		.decel_energy_backup(decel_energy_backup));
	from_fault_map i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fault_in(fault_in), .drive_phase(drive_phase), .decel_energy_backup(decel_energy_backup),
		.heavy_or_sensorless(heavy_or_sensorless), .heatsink_temp(heatsink_temp),
		.above_base_freq(above_base_freq), .stall_base(stall_base), .terminal_func(terminal_func),
		.terminal_out(terminal_out), .overheat_warning(overheat_warning),
		.undervoltage_at_stop(undervoltage_at_stop), .overheat_trip(overheat_trip), .stall_level(stall_level));
	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		q = prdata;
		`CHK("slave error", 1'b0, pslverr)
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		apb(1'b1, a, {16'h0000, d}, q);
	endtask : wr
	task automatic reg_chk(input logic [7:0] a, input logic [15:0] e, input string what);
		logic [31:0] q;
		apb(1'b0, a, 32'h0000_0000, q);
		`CHK(what, {16'h0000, e}, q)
	endtask : reg_chk
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : settle
	task automatic t_reset();
		reg_chk(from_pkg::OFS_OH_LEVEL, 16'h041A, "warning level");
		reg_chk(from_pkg::OFS_STALL_LIMIT, 16'h0064, "stall limit");
		reg_chk(from_pkg::OFS_RECORD, 16'h0000, "record");
		for (int i = 0; i < 4; i++) begin
			reg_chk(from_pkg::OFS_OPTION_1 + 8'(4 * i), 16'h0000, "option");
		end
		reg_chk(8'h40, 16'h0000, "unmapped");
		`CHK("terminals", 4'h0, terminal_out)
		$display("reset test done");
	endtask : t_reset
	task automatic t_regs();
		wr(from_pkg::OFS_OPTION_4, 16'hFFFF);
		reg_chk(from_pkg::OFS_OPTION_4, 16'hFFFF, "option 4");
		wr(from_pkg::OFS_OH_LEVEL, 16'h044D);
		reg_chk(from_pkg::OFS_OH_LEVEL, 16'h041A, "level refused");
		wr(from_pkg::OFS_OH_LEVEL, 16'h044C);
		reg_chk(from_pkg::OFS_OH_LEVEL, 16'h044C, "level top");
		wr(from_pkg::OFS_OH_LEVEL, 16'h041A);
		wr(from_pkg::OFS_STALL_LIMIT, 16'h0065);
		reg_chk(from_pkg::OFS_STALL_LIMIT, 16'h0064, "limit refused");
		wr(from_pkg::OFS_RECORD, 16'h0055);
		reg_chk(from_pkg::OFS_RECORD, 16'h0000, "record read only");
		$display("register test done");
	endtask : t_regs
	task automatic t_record();
		i_det.raise_fault(from_pkg::FC_OC_STOP, from_pkg::FROM_PH_STOP);
		reg_chk(from_pkg::OFS_RECORD, 16'h0006, "record stop current");
		i_det.raise_fault(from_pkg::FC_UV_STOP, from_pkg::FROM_PH_STOP);
		#1;
		`CHK("undervoltage at stop", 1'b1, undervoltage_at_stop)
		reg_chk(from_pkg::OFS_RECORD, 16'h0006, "no record at stop");
		i_det.raise_fault(from_pkg::FC_UV_ACC, from_pkg::FROM_PH_ACC);
		reg_chk(from_pkg::OFS_RECORD, 16'h000B, "record undervoltage");
		i_det.fire_backup();
		reg_chk(from_pkg::OFS_RECORD, 16'h003E, "record backup");
		wr(from_pkg::OFS_CLEAR, 16'h0001);
		$display("record test done");
	endtask : t_record
	// Option 3 selects every other category and terminal 4 all of them, so only 1 and 4 may fire.
	task automatic t_category();
		for (int b = 0; b < 7; b++) begin
			wr(from_pkg::OFS_OPTION_1, 16'(1 << b));
			wr(from_pkg::OFS_OPTION_2, 16'h0000);
			wr(from_pkg::OFS_OPTION_3, 16'h007F & ~16'(1 << b));
			wr(from_pkg::OFS_OPTION_4, 16'h007F);
			i_det.raise_fault(cat_code[b], from_pkg::FROM_PH_RUN);
			settle(3);
			`CHK("terminals", 4'b1001, terminal_out)
			reg_chk(from_pkg::OFS_STATUS, {8'h00, cat_code[b]}, "status");
			wr(from_pkg::OFS_CLEAR, 16'h0001);
			settle(3);
			`CHK("terminals idle", 4'b0000, terminal_out)
		end
		// Terminal 4 now carries option 1's function, so it must stay idle although option 4 matches.
		i_det.raise_fault(from_pkg::FC_OC_STOP, from_pkg::FROM_PH_RUN);
		terminal_func[3] <= 8'h23;
		settle(3);
		`CHK("terminal function", 4'b0100, terminal_out)
		wr(from_pkg::OFS_CLEAR, 16'h0001);
		terminal_func[3] <= 8'h26;
		$display("category test done");
	endtask : t_category
	task automatic heat(input logic hv, input logic [15:0] t, input logic w, input logic tr);
		@(posedge sys_clk);
		heavy_or_sensorless <= hv;
		heatsink_temp <= t;
		settle(3);
		`CHK("warning", w, overheat_warning)
		`CHK("trip", tr, overheat_trip)
	endtask : heat
	task automatic t_heat();
		heat(1'b0, 16'h0419, 1'b0, 1'b0);
		heat(1'b0, 16'h041A, 1'b1, 1'b0);
		heat(1'b0, 16'h044C, 1'b1, 1'b1);
		heat(1'b1, 16'h03E7, 1'b0, 1'b0);
		heat(1'b1, 16'h03E8, 1'b0, 1'b1);
		heat(1'b1, 16'h041A, 1'b0, 1'b1);
		wr(from_pkg::OFS_OH_LEVEL, 16'h0384);
		heat(1'b1, 16'h03B6, 1'b1, 1'b0);
		wr(from_pkg::OFS_OH_LEVEL, 16'h041A);
		heat(1'b0, 16'h0000, 1'b0, 1'b0);
		$display("heat test done");
	endtask : t_heat
	task automatic t_stall();
		wr(from_pkg::OFS_STALL_LIMIT, 16'h0050);
		@(posedge sys_clk);
		stall_base <= {16'h0096, 16'h0064};
		above_base_freq <= 1'b1;
		settle(3);
		`CHK("stall scaled", 32'h0078_0050, stall_level)
		@(posedge sys_clk);
		above_base_freq <= 1'b0;
		settle(3);
		`CHK("stall unscaled", 32'h0096_0064, stall_level)
		$display("stall test done");
	endtask : t_stall
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_regs();
		t_record();
		t_category();
		t_heat();
		t_stall();
		stop_test();
	end
	initial begin
		#400000;
		err_count++;
		$display("watchdog expired");
		stop_test();
	end
endmodule : fault_record_output_map_tb
